// File: common/seb_pkg.sv
// seb_pkg: shared constants and carrier types for the shared enable latch bank
package seb_pkg;

   // ************************************************************
   // widths
   // ************************************************************
   localparam int ENABLE_W = 2;               // shared enable bus width
   localparam int ADDR_W   = 8;               // axi4-lite address width
   localparam int DATA_W   = 32;              // axi4-lite data width
   localparam int STRB_W   = DATA_W / 8;
   localparam int INT_W    = 5;               // interrupt event count

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [ADDR_W-1:0] CTRL_ADDR       = 8'h00;
   localparam logic [ADDR_W-1:0] LATCH_STAT_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] INT_STAT_ADDR   = 8'h08;
   localparam logic [ADDR_W-1:0] INT_MASK_ADDR   = 8'h0C;

   // ctrl fields
   localparam int CTRL_LATCH_CLR_BIT = 0;     // software latch clear, level

   // latch status fields
   localparam int STAT_DRIVER_LSB   = 0;      // two bits: primary, secondary
   localparam int STAT_SELFTEST_LSB = 2;      // two bits: tx, rx (low = test)
   localparam int STAT_RXPOWER_BIT  = 4;
   localparam int STAT_FAULT_BIT    = 5;      // high while link fault
   localparam int STAT_COND_LSB     = 6;      // three raw receive conditions

   // interrupt event bits
   localparam int EV_DRIVER_CAP   = 0;
   localparam int EV_SELFTEST_CAP = 1;
   localparam int EV_RXPOWER_CAP  = 2;
   localparam int EV_FAULT_RISE   = 3;
   localparam int EV_FAULT_FALL   = 4;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [ENABLE_W-1:0] DRIVER_RST   = 2'h0;  // both drivers off
   localparam logic [ENABLE_W-1:0] SELFTEST_RST = 2'h3;  // self-test off
   localparam logic [0:0]          RXPOWER_RST  = 1'h0;  // receiver off
   localparam logic [DATA_W-1:0]   CTRL_RST     = 32'h0000_0000;
   localparam logic [INT_W-1:0]    INT_MASK_RST = 5'h00;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic driverEnableLatchStrobe;
      logic selftestLatchStrobe;
      logic rxPowerLatchStrobe;
   } seb_strobes_t;

   typedef struct packed {
      logic freqOutOfRange;
      logic amplitudeLow;
      logic densityLow;
   } seb_rx_cond_t;

endpackage

// File: src/seb_latch_bank.sv
// seb_latch_bank: shared enable latch bank with link fault and axi4-lite access
//
// Overview of operation
// RL1: driver strobe high: driver enables follow the shared enable bus.
// RL2: driver strobe falls: bus value held as driver enables until reopened.
// RL3: device reset sampled low clears driver latch, both drivers off.
// RL4: self-test strobe high: bus sets self-test enables, low bit means test.
// RL5: self-test strobe falls: last bus value held in self-test latch.
// RL6: reset while self-test latch closed disables self-test on tx and rx.
// RL7: rx power strobe high: bus bit 0 drives receiver power, high on.
// RL8: rx power strobe falls: last bus bit 0 held as receiver power.
// RL9: reset while rx power latch closed disables the receive channel.
// RL10: one bus feeds all latches; each follows only under its own strobe.
// RL11: active-low link fault asserts on any of three receive conditions or receiver off.
// RL12: device reset active low, sampled on the clock, clears the driver latch, and the other two latches only while closed.
// RL13: bit-to-channel mapping of drivers and self-test enables is a parameter.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
module seb_latch_bank
   import seb_pkg::*;
#(
   parameter bit DRIVER_SWAP   = 1'b0,  // 1: bus bit 1 to primary driver
   parameter bit SELFTEST_SWAP = 1'b0   // 1: bus bit 1 to tx self-test
) (
   input  wire logic                          mclk,
   input  wire logic                          reset_n,
   input  wire logic                          ce,
   // latch pins
   input  wire seb_pkg::seb_strobes_t         strobes,
   input  wire logic [seb_pkg::ENABLE_W-1:0]  sharedEnableBus,
   input  wire logic                          deviceReset_n,
   input  wire seb_pkg::seb_rx_cond_t         rxCond,
   output logic      [seb_pkg::ENABLE_W-1:0]  serialOutDriverEn,
   output logic      [seb_pkg::ENABLE_W-1:0]  selftestEn_n,
   output logic                               rxPowerEn,
   output logic                               linkFault_n,
   output logic                               irq,
   // axi4-lite slave
   input  wire logic [seb_pkg::ADDR_W-1:0]    awaddr,
   input  wire logic                          awvalid,
   output logic                               awready,
   input  wire logic [seb_pkg::DATA_W-1:0]    wdata,
   input  wire logic [seb_pkg::STRB_W-1:0]    wstrb,
   input  wire logic                          wvalid,
   output logic                               wready,
   output logic      [1:0]                    bresp,
   output logic                               bvalid,
   input  wire logic                          bready,
   input  wire logic [seb_pkg::ADDR_W-1:0]    araddr,
   input  wire logic                          arvalid,
   output logic                               arready,
   output logic      [seb_pkg::DATA_W-1:0]    rdata,
   output logic      [1:0]                    rresp,
   output logic                               rvalid,
   input  wire logic                          rready
);

   import seb_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   logic [ENABLE_W-1:0] driverBus;
   logic [ENABLE_W-1:0] selftestBus;
   logic                latchClrReq;
   logic                driverCap;
   logic                selftestCap;
   logic                rxPowerCap;
   logic                faultNow;
   logic [INT_W-1:0]    events;
   logic [INT_W-1:0]    intClear;
   logic [INT_W-1:0]    intStat_r;
   logic [INT_W-1:0]    intStat_nxt;
   logic [INT_W-1:0]    intMask_r;
   logic [DATA_W-1:0]   ctrl_r;
   logic [ADDR_W-1:0]   wrAddr_r;
   logic [DATA_W-1:0]   wrData_r;
   logic [STRB_W-1:0]   wrStrb_r;
   logic                wrFire;
   logic                wrHit;
   logic [DATA_W-1:0]   rdValue;
   logic                rdHit;
   logic [DATA_W-1:0]   latchStat;

   // ************************************************************
   // bit mapping and latch clear
   // ************************************************************
   // channel mapping applied before the latches so outputs stay flops
   assign driverBus   = DRIVER_SWAP ? {sharedEnableBus[0], sharedEnableBus[1]}
                                    : sharedEnableBus;  // RL13
   assign selftestBus = SELFTEST_SWAP ? {sharedEnableBus[0], sharedEnableBus[1]}
                                      : sharedEnableBus;  // RL13

   // device reset pin sampled on the clock, or the software clear
   assign latchClrReq = ~deviceReset_n | ctrl_r[CTRL_LATCH_CLR_BIT];  // RL12

   // ************************************************************
   // the three latches, each opened only by its own strobe
   // ************************************************************
   // serial driver enables, cleared regardless of strobe
   seb_latch_cell #(
      .WIDTH           (ENABLE_W),
      .RST_VAL         (DRIVER_RST),
      .CLR_ONLY_CLOSED (1'b0)
   ) uDriver (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .ce       (ce),
      .strobe   (strobes.driverEnableLatchStrobe),  // RL10
      .busIn    (driverBus),                        // RL1
      .clrReq   (latchClrReq),                      // RL3
      .latchOut (serialOutDriverEn),                // RL2
      .captured (driverCap)
   );

   // self-test enables, active low, cleared only while closed
   seb_latch_cell #(
      .WIDTH           (ENABLE_W),
      .RST_VAL         (SELFTEST_RST),
      .CLR_ONLY_CLOSED (1'b1)
   ) uSelftest (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .ce       (ce),
      .strobe   (strobes.selftestLatchStrobe),      // RL10
      .busIn    (selftestBus),                      // RL4
      .clrReq   (latchClrReq),                      // RL6
      .latchOut (selftestEn_n),                     // RL5
      .captured (selftestCap)
   );

   // receive power enable from bus bit 0, cleared only while closed
   seb_latch_cell #(
      .WIDTH           (1),
      .RST_VAL         (RXPOWER_RST),
      .CLR_ONLY_CLOSED (1'b1)
   ) uRxPower (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .ce       (ce),
      .strobe   (strobes.rxPowerLatchStrobe),       // RL10
      .busIn    (sharedEnableBus[0]),               // RL7
      .clrReq   (latchClrReq),                      // RL9
      .latchOut (rxPowerEn),                        // RL8
      .captured (rxPowerCap)
   );

   // ************************************************************
   // link fault
   // ************************************************************
   // any receive condition, or the receiver powered down
   assign faultNow = rxCond.freqOutOfRange | rxCond.amplitudeLow
                   | rxCond.densityLow | ~rxPowerEn;  // RL11

   // active-low fault output
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         linkFault_n <= 1'b0;           // receiver is off after reset
      end else if (ce) begin
         linkFault_n <= ~faultNow;      // RL11
      end
   end

   // ************************************************************
   // interrupts
   // ************************************************************
   // events: three captures and both fault edges
   assign events[EV_DRIVER_CAP]   = driverCap;
   assign events[EV_SELFTEST_CAP] = selftestCap;
   assign events[EV_RXPOWER_CAP]  = rxPowerCap;
   assign events[EV_FAULT_RISE]   = faultNow & linkFault_n;
   assign events[EV_FAULT_FALL]   = ~faultNow & ~linkFault_n;

   // write-one-to-clear, a new event wins over its clear
   assign intClear    = (wrFire && wrAddr_r == INT_STAT_ADDR && wrStrb_r[0])
                        ? wrData_r[INT_W-1:0] : '0;
   assign intStat_nxt = (intStat_r & ~intClear) | events;

   // sticky status and level interrupt
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         intStat_r <= '0;
         irq       <= 1'b0;
      end else if (ce) begin
         intStat_r <= intStat_nxt;
         irq       <= |(intStat_nxt & intMask_r);
      end
   end

   // ************************************************************
   // axi4-lite write channel
   // ************************************************************
   // write performed once address and data are both held
   assign wrFire = ~awready & ~wready & ~bvalid;

   // address decode for writes
   always_comb begin
      if (wrAddr_r == CTRL_ADDR) begin
         wrHit = 1'b1;
      end else if (wrAddr_r == LATCH_STAT_ADDR) begin
         wrHit = 1'b1;                  // read-only, write ignored
      end else if (wrAddr_r == INT_STAT_ADDR) begin
         wrHit = 1'b1;
      end else if (wrAddr_r == INT_MASK_ADDR) begin
         wrHit = 1'b1;
      end else begin
         wrHit = 1'b0;
      end
   end

   // address, data and response handshakes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         awready  <= 1'b1;
         wready   <= 1'b1;
         bvalid   <= 1'b0;
         bresp    <= RESP_OKAY;
         wrAddr_r <= '0;
         wrData_r <= '0;
         wrStrb_r <= '0;
      end else if (ce) begin
         if (awvalid && awready) begin
            wrAddr_r <= awaddr;
            awready  <= 1'b0;
         end
         if (wvalid && wready) begin
            wrData_r <= wdata;
            wrStrb_r <= wstrb;
            wready   <= 1'b0;
         end
         if (wrFire) begin
            bvalid <= 1'b1;
            bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // control and mask registers, low byte lane only
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r    <= CTRL_RST;
         intMask_r <= INT_MASK_RST;
      end else if (ce && wrFire && wrStrb_r[0]) begin
         if (wrAddr_r == CTRL_ADDR) begin
            ctrl_r <= {{(DATA_W-1){1'b0}}, wrData_r[CTRL_LATCH_CLR_BIT]};
         end else if (wrAddr_r == INT_MASK_ADDR) begin
            intMask_r <= wrData_r[INT_W-1:0];
         end
      end
   end

   // ************************************************************
   // axi4-lite read channel
   // ************************************************************
   // live latch and receive state
   always_comb begin
      latchStat = '0;
      latchStat[STAT_DRIVER_LSB +: ENABLE_W]   = serialOutDriverEn;
      latchStat[STAT_SELFTEST_LSB +: ENABLE_W] = selftestEn_n;
      latchStat[STAT_RXPOWER_BIT]              = rxPowerEn;
      latchStat[STAT_FAULT_BIT]                = ~linkFault_n;
      latchStat[STAT_COND_LSB +: 3]            = rxCond;
   end

   // read decode, unmapped reads zero with an error
   always_comb begin
      rdHit   = 1'b1;
      rdValue = '0;
      if (araddr == CTRL_ADDR) begin
         rdValue = ctrl_r;
      end else if (araddr == LATCH_STAT_ADDR) begin
         rdValue = latchStat;
      end else if (araddr == INT_STAT_ADDR) begin
         rdValue[INT_W-1:0] = intStat_r;
      end else if (araddr == INT_MASK_ADDR) begin
         rdValue[INT_W-1:0] = intMask_r;
      end else begin
         rdHit = 1'b0;
      end
   end

   // read address and data handshakes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rdValue;
            rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule

// File: src/seb_latch_cell.sv
// seb_latch_cell: one clocked enable latch, transparent while its strobe is high
module seb_latch_cell #(
   parameter int               WIDTH           = 2,
   parameter logic [WIDTH-1:0] RST_VAL         = '0,
   parameter bit               CLR_ONLY_CLOSED = 1'b0
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             ce,
   input  wire logic             strobe,
   input  wire logic [WIDTH-1:0] busIn,
   input  wire logic             clrReq,
   output logic      [WIDTH-1:0] latchOut,
   output logic                  captured
);

   logic strobePrev_r;
   logic clrOk;

   // clear allowed always, or only while closed for the guarded latches
   assign clrOk = clrReq & (~CLR_ONLY_CLOSED | ~strobe);

   // latch body: clear, follow while open, hold while closed
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         latchOut <= RST_VAL;
      end else if (ce) begin
         if (clrOk) begin
            latchOut <= RST_VAL;
         end else if (strobe) begin
            latchOut <= busIn;          // last value before the fall is kept
         end
      end
   end

   // falling edge of the strobe marks a capture
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         strobePrev_r <= 1'b0;
         captured     <= 1'b0;
      end else if (ce) begin
         strobePrev_r <= strobe;
         captured     <= strobePrev_r & ~strobe;
      end
   end

endmodule

// File: test/seb_host_model.sv
// seb_host_model: host logic driving strobes, enable bus and conditions
module seb_host_model (
   input  wire logic                         mclk,
   output seb_pkg::seb_strobes_t             strobes,
   output logic [seb_pkg::ENABLE_W-1:0]      sharedEnableBus,
   output logic                              deviceReset_n,
   output seb_pkg::seb_rx_cond_t             rxCond
);
   timeunit 1ns;
   timeprecision 1ps;
   import seb_pkg::*;
   // idle: strobes closed, reset off
   initial begin
      strobes = '0;
      sharedEnableBus = '0;
      deviceReset_n = 1'b1;
      rxCond = '0;
   end
   // present a bus value and conditions under the strobes given in s
   task automatic drive(input logic [2:0] s, input logic [1:0] b, input logic [2:0] c);
      @(posedge mclk);
      strobes <= s;
      sharedEnableBus <= b;
      rxCond <= c;
   endtask
   // close strobes; released bus no longer holds its value
   task automatic release_all();
      @(posedge mclk);
      strobes <= '0;
      sharedEnableBus <= ~sharedEnableBus;
   endtask
   task automatic load(input logic [2:0] s, input logic [1:0] b, input logic [2:0] c);
      drive(s, b, c);
      release_all();
   endtask
   // one clock of device reset, sampled on the clock
   task automatic dev_reset(input logic [2:0] s, input logic [1:0] b);
      @(posedge mclk);
      deviceReset_n <= 1'b0;
      strobes <= s;
      sharedEnableBus <= b;
      @(posedge mclk);
      deviceReset_n <= 1'b1;
      strobes <= '0;
   endtask
endmodule

// File: test/seb_latch_bank_monitor.sv
// seb_latch_bank_monitor: port checks for the latch bank
module seb_latch_bank_monitor #(
   parameter bit DRIVER_SWAP   = 1'b0,
   parameter bit SELFTEST_SWAP = 1'b0
) (
   input wire logic                         mclk,
   input wire logic                         reset_n,
   input wire logic                         ce,
   input wire seb_pkg::seb_strobes_t        strobes,
   input wire logic [seb_pkg::ENABLE_W-1:0] sharedEnableBus,
   input wire logic                         deviceReset_n,
   input wire seb_pkg::seb_rx_cond_t        rxCond,
   input wire logic [seb_pkg::ENABLE_W-1:0] serialOutDriverEn,
   input wire logic [seb_pkg::ENABLE_W-1:0] selftestEn_n,
   input wire logic                         rxPowerEn,
   input wire logic                         linkFault_n,
   input wire logic                         irq
);
   timeunit 1ns;
   timeprecision 1ps;
   import seb_pkg::*;
   logic [ENABLE_W-1:0] drvMap;
   logic [ENABLE_W-1:0] stMap;
   // ************
   // bus mapping
   // ************
   // swapped or straight bus per latch
   assign drvMap = DRIVER_SWAP ? {sharedEnableBus[0], sharedEnableBus[1]} : sharedEnableBus;
   assign stMap = SELFTEST_SWAP ? {sharedEnableBus[0], sharedEnableBus[1]} : sharedEnableBus;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ************
   // checks
   // ************
   a_drv_follow: assert property (
      strobes.driverEnableLatchStrobe && deviceReset_n && ce |=> serialOutDriverEn == $past(drvMap))
      else $error("driver follow");
   a_drv_hold: assert property (
      !strobes.driverEnableLatchStrobe && ce
      |=> $stable(serialOutDriverEn) || serialOutDriverEn == DRIVER_RST) else $error("driver hold");
   a_drv_reset: assert property (
      !deviceReset_n && ce |=> serialOutDriverEn == DRIVER_RST) else $error("driver reset");
   a_st_follow: assert property (
      strobes.selftestLatchStrobe && ce |=> selftestEn_n == $past(stMap)) else $error("test follow");
   a_st_hold: assert property (
      !strobes.selftestLatchStrobe && ce
      |=> $stable(selftestEn_n) || selftestEn_n == SELFTEST_RST) else $error("test hold");
   a_st_reset: assert property (
      !deviceReset_n && !strobes.selftestLatchStrobe && ce |=> selftestEn_n == SELFTEST_RST)
      else $error("test reset");
   a_rx_follow: assert property (
      strobes.rxPowerLatchStrobe && ce |=> rxPowerEn == $past(sharedEnableBus[0]))
      else $error("rx follow");
   a_rx_hold: assert property (
      !strobes.rxPowerLatchStrobe && ce |=> $stable(rxPowerEn) || !rxPowerEn)
      else $error("rx hold");
   a_rx_reset: assert property (
      !deviceReset_n && !strobes.rxPowerLatchStrobe && ce |=> !rxPowerEn) else $error("rx reset");
   a_fault_or: assert property (
      ce |=> linkFault_n == !($past(|rxCond) || !$past(rxPowerEn))) else $error("fault or");
   c_drv_cap: cover property ($fell(strobes.driverEnableLatchStrobe));
   c_fault: cover property ($fell(linkFault_n));
   c_irq: cover property ($rose(irq));
endmodule

bind seb_latch_bank seb_latch_bank_monitor #(
   .DRIVER_SWAP(DRIVER_SWAP),
   .SELFTEST_SWAP(SELFTEST_SWAP)
) i_seb_latch_bank_monitor (
   .mclk(mclk), .reset_n(reset_n), .ce(ce), .strobes(strobes),
   .sharedEnableBus(sharedEnableBus), .deviceReset_n(deviceReset_n), .rxCond(rxCond),
   .serialOutDriverEn(serialOutDriverEn), .selftestEn_n(selftestEn_n),
   .rxPowerEn(rxPowerEn), .linkFault_n(linkFault_n), .irq(irq)
);

// File: test/tb_seb_latch_bank.sv
// tb_seb_latch_bank: self-checking bench for the latch bank
module tb_seb_latch_bank;
   timeunit 1ns;
   timeprecision 1ps;
   import seb_pkg::*;
   typedef struct packed {
      logic [2:0] sel;
      logic [1:0] bus;
      logic [2:0] cond;
      logic [1:0] drv;
      logic [1:0] st;
      logic       rx;
   } seb_row_t;
   logic mclk = 0, reset_n = 0, ce = 1, deviceReset_n, irq, rxPowerEn, linkFault_n;
   seb_strobes_t strobes;
   seb_rx_cond_t rxCond;
   logic [1:0] sharedEnableBus, serialOutDriverEn, selftestEn_n, bresp, rresp;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, dataGot;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] respGot;
   logic [1:0] swDrv, swSt;
   int bad_count = 0, n_checks = 0;
   // accumulated latch state after each load
   seb_row_t rows [8] = '{
      {3'h4, 2'h2, 3'h0, 2'h2, 2'h3, 1'h0}, {3'h2, 2'h1, 3'h0, 2'h2, 2'h1, 1'h0},
      {3'h1, 2'h1, 3'h0, 2'h2, 2'h1, 1'h1}, {3'h4, 2'h1, 3'h4, 2'h1, 2'h1, 1'h1},
      {3'h2, 2'h2, 3'h2, 2'h1, 2'h2, 1'h1}, {3'h1, 2'h3, 3'h1, 2'h1, 2'h2, 1'h1},
      {3'h1, 2'h0, 3'h0, 2'h1, 2'h2, 1'h0}, {3'h1, 2'h1, 3'h0, 2'h1, 2'h2, 1'h1}};
   seb_latch_bank i_seb_latch_bank (.mclk(mclk), .reset_n(reset_n), .ce(ce),
      .strobes(strobes), .sharedEnableBus(sharedEnableBus), .deviceReset_n(deviceReset_n),
      .rxCond(rxCond), .serialOutDriverEn(serialOutDriverEn), .selftestEn_n(selftestEn_n),
      .rxPowerEn(rxPowerEn), .linkFault_n(linkFault_n), .irq(irq), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   seb_host_model i_seb_host_model (.mclk(mclk), .strobes(strobes),
      .sharedEnableBus(sharedEnableBus), .deviceReset_n(deviceReset_n), .rxCond(rxCond));
   // second bank with both channel maps swapped, same latch pins, bus idle
   seb_latch_bank #(.DRIVER_SWAP(1'b1), .SELFTEST_SWAP(1'b1)) i_seb_latch_bank_swap (
      .mclk(mclk), .reset_n(reset_n), .ce(ce), .strobes(strobes),
      .sharedEnableBus(sharedEnableBus), .deviceReset_n(deviceReset_n), .rxCond(rxCond),
      .serialOutDriverEn(swDrv), .selftestEn_n(swSt), .rxPowerEn(), .linkFault_n(), .irq(),
      .awaddr(8'h00), .awvalid(1'b0), .awready(), .wdata(32'h0000_0000), .wstrb(4'h0),
      .wvalid(1'b0), .wready(), .bresp(), .bvalid(), .bready(1'b0), .araddr(8'h00),
      .arvalid(1'b0), .arready(), .rdata(), .rresp(), .rvalid(), .rready(1'b0));
   // 50 ns clock
   initial begin
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_lat(input logic [1:0] d, input logic [1:0] s, input logic r);
      chk({serialOutDriverEn, selftestEn_n, rxPowerEn}, {d, s, r});
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      respGot = bresp;
      bready <= 1'b0;
      if (k == 50) bad_count++;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      int k;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      dataGot = rdata;
      respGot = rresp;
      rready <= 1'b0;
      if (k == 50) bad_count++;
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog
   initial begin
      #200000;
      bad_count++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      #1;
      chk_lat(2'h0, 2'h3, 1'b0);
      chk({linkFault_n, irq}, 2'h0);
      foreach (rows[i]) begin
         i_seb_host_model.load(rows[i].sel, rows[i].bus, rows[i].cond);
         @(posedge mclk);
         #1;
         chk_lat(rows[i].drv, rows[i].st, rows[i].rx);
         chk(linkFault_n, !(|rows[i].cond) && rows[i].rx);
         chk({swDrv, swSt}, {rows[i].drv[0], rows[i].drv[1], rows[i].st[0], rows[i].st[1]});
      end
      $display("row loop done");
      chk(irq, 1'b0);
      axi_wr(INT_MASK_ADDR, 32'h1);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b1);
      axi_rd(INT_STAT_ADDR);
      chk(dataGot, 32'h1F);
      axi_wr(INT_STAT_ADDR, 32'h1F);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0);
      axi_wr(LATCH_STAT_ADDR, 32'h0);
      chk(respGot, RESP_OKAY);
      axi_rd(LATCH_STAT_ADDR);
      chk(dataGot, 32'h19);
      axi_rd(8'h10);
      chk(dataGot, 32'h0000_0000);
      chk(respGot, RESP_SLVERR);
      axi_wr(8'h20, 32'h1);
      chk(respGot, RESP_SLVERR);
      axi_wr(CTRL_ADDR, 32'h1);
      repeat (2) @(posedge mclk);
      chk_lat(2'h0, 2'h3, 1'b0);
      axi_wr(CTRL_ADDR, 32'h0);
      $display("register tests done");
      // transparent while strobe open, then hold against a moving bus
      i_seb_host_model.drive(3'h4, 2'h1, 3'h0);
      i_seb_host_model.drive(3'h4, 2'h2, 3'h0);
      #1;
      chk(serialOutDriverEn, 2'h1);
      i_seb_host_model.release_all();
      #1;
      chk(serialOutDriverEn, 2'h2);
      @(posedge mclk);
      #1;
      chk(serialOutDriverEn, 2'h2);
      // clock enable low: an open strobe must not move the latch
      @(posedge mclk);
      ce <= 1'b0;
      i_seb_host_model.load(3'h4, 2'h0, 3'h0);
      #1;
      chk(serialOutDriverEn, 2'h2);
      @(posedge mclk);
      ce <= 1'b1;
      i_seb_host_model.load(3'h2, 2'h0, 3'h0);
      i_seb_host_model.load(3'h1, 2'h1, 3'h0);
      i_seb_host_model.dev_reset(3'h0, 2'h0);
      #1;
      chk_lat(2'h0, 2'h3, 1'b0);
      i_seb_host_model.load(3'h4, 2'h3, 3'h0);
      i_seb_host_model.dev_reset(3'h2, 2'h2);
      #1;
      chk_lat(2'h0, 2'h2, 1'b0);
      $display("latch tests done");
      end_sim();
   end
endmodule
